//--- dpc_defines.vh
// Register offsets, field positions and timing counts for the DS3 counter block
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
`define DPC_ADDR_FAR_END_ERR    8'h04
`define DPC_ADDR_PARITY_FRAME   8'h05
`define DPC_ADDR_PBIT_ERR       8'h06
`define DPC_ADDR_LOOP_CMD       8'h07
`define DPC_BIT_GO              7
`define DPC_BIT_UP_DOWN         6
`define DPC_BIT_METHOD          5
`define DPC_CNT_MAX             8'hff
`define DPC_CMD_RESET           8'h00
`define DPC_CODE_ALL            5'h00
`define DPC_CODE_DS3            5'h02
`define DPC_CODE_DS1_FIRST      5'h04
`define DPC_FEAC_CONNECT        6'h07
`define DPC_FEAC_DISCONNECT     6'h1c
`define DPC_FEAC_REPEATS        4'ha
`define DPC_FEAC_WORD_BITS      5'h10
`endif

//--- dpc_sat_counter.v
// Saturating clear-on-read counter with one held increment
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_sat_counter #(
  parameter WIDTH = 8
) (
  // Clock and control
  input  wire             clk_in,
  input  wire             reset_n_in,
  input  wire             clk_en_in,
  // Events
  input  wire             inc_in,
  input  wire             inhibit_in,
  input  wire             read_busy_in,
  input  wire             read_clear_in,
  // Value
  output reg  [WIDTH-1:0] count_out
);
  reg held_q;
  wire take = inc_in & ~inhibit_in;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_out <= {WIDTH{1'b0}};
      held_q    <= 1'b0;
    end else if (clk_en_in) begin
      if (read_clear_in) begin
        count_out <= {WIDTH{1'b0}};
        // held increment applies after the clear
        held_q    <= held_q | take;
      end else if (read_busy_in) begin
        if (take)
          held_q <= 1'b1;
      end else begin
        if ((take | held_q) && (count_out != {WIDTH{1'b1}}))
          count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
        held_q <= held_q & take;
      end
    end
  end
endmodule

//--- dpc_perf_loop.v
// DS3 performance counters and remote loopback command transmitter
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_perf_loop (
  // Clock and reset
  input  wire       clk_in,
  input  wire       reset_n_in,
  input  wire       clk_en_in,
  // Host register port
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Mode and configuration
  input  wire       cbit_mode_in,
  input  wire [3:0] inversion_pattern_select_in,
  input  wire       feac_clock_select_in,
  // Receive framer events
  input  wire       frame_tick_in,
  input  wire [2:0] febe_bits_in,
  input  wire       fm_bit_err_in,
  input  wire       cparity_err_in,
  input  wire       pbit_err_in,
  input  wire       ds3_los_in,
  input  wire       ds3_oof_in,
  // Transmit side
  input  wire       feac_bit_tick_in,
  output reg        feac_bit_out,
  output reg        inversion_active_out,
  output reg  [4:0] inversion_target_out,
  output reg  [3:0] inversion_pattern_out,
  output reg        feac_busy_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CMD  = 2'h1;
  localparam ST_CHAN = 2'h2;
  localparam ST_DONE = 2'h3;

  // Codeword is 0xxxxxx0 11111111, sent LSB first
  function [15:0] feac_word;
    input [5:0] code;
    begin
      feac_word = {8'hff, 1'b0, code, 1'b0};
    end
  endfunction

  // Channel codes map onto FEAC codewords by value
  function [5:0] chan_code;
    input [4:0] tgt;
    begin
      chan_code = {1'b0, tgt};
    end
  endfunction

  // Address match shared by the read strobes and the clears
  function is_addr;
    input [7:0] a;
    input [7:0] want;
    begin
      is_addr = (a == want);
    end
  endfunction
  // Counter width is the register width
  localparam CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for framer pins
  // Two stages per pin; only the edge detectors look past the second
  reg [8:0] s1_q;
  reg [8:0] s2_q;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
    end else if (clk_en_in) begin
      s1_q <= {feac_bit_tick_in, ds3_oof_in, ds3_los_in, pbit_err_in, cparity_err_in,
               fm_bit_err_in, febe_bits_in[2], febe_bits_in[1], febe_bits_in[0]};
      s2_q <= s1_q;
    end
  end
  // Frame tick qualifies the FEBE bits; it is synchronised alongside
  reg ft1_q;
  reg ft2_q;
  reg ft3_q;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      ft1_q <= 1'b0;
      ft2_q <= 1'b0;
      ft3_q <= 1'b0;
    end else if (clk_en_in) begin
      ft1_q <= frame_tick_in;
      ft2_q <= ft1_q;
      ft3_q <= ft2_q;
    end
  end
  wire frame_ev = ft2_q & ~ft3_q;
  reg  tk3_q;
  always @(posedge clk_in) begin
    if (!reset_n_in)
      tk3_q <= 1'b0;
    else if (clk_en_in)
      tk3_q <= s2_q[8];
  end
  wire bit_ev = s2_q[8] & ~tk3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Counter events
  // inhibit on LOS or OOF
  wire inhibit = s2_q[6] | s2_q[7];
  // any FEBE bit zero in a frame
  wire febe_ev = frame_ev & ~(&s2_q[2:0]);
  // M13 counts F and M bit errors
  wire fb_inc  = cbit_mode_in ? febe_ev : s2_q[3];
  wire cp_inc  = cbit_mode_in ? s2_q[4] : frame_ev;
  wire pp_inc  = s2_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // Read in progress for a level-held rd_in; clear on its falling edge
  reg        rd_q;
  reg  [7:0] rd_addr_q;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_q      <= 1'b0;
      rd_addr_q <= 8'h00;
    end else if (clk_en_in) begin
      rd_q <= rd_in;
      if (rd_in)
        rd_addr_q <= addr_in;
    end
  end
  wire rd_end = rd_q & ~rd_in;
  wire [7:0] cnt_fb;
  wire [7:0] cnt_cp;
  wire [7:0] cnt_pp;
  // busy from the sampling edge on, so no count slips past the read data
  wire busy_fb = (rd_in && is_addr(addr_in, `DPC_ADDR_FAR_END_ERR)) ||
                 (rd_q && is_addr(rd_addr_q, `DPC_ADDR_FAR_END_ERR));
  wire busy_cp = (rd_in && is_addr(addr_in, `DPC_ADDR_PARITY_FRAME)) ||
                 (rd_q && is_addr(rd_addr_q, `DPC_ADDR_PARITY_FRAME));
  wire busy_pp = (rd_in && is_addr(addr_in, `DPC_ADDR_PBIT_ERR)) ||
                 (rd_q && is_addr(rd_addr_q, `DPC_ADDR_PBIT_ERR));
  // clear where the strobe drops, after the data was taken
  wire clr_fb  = rd_end && is_addr(rd_addr_q, `DPC_ADDR_FAR_END_ERR);
  wire clr_cp  = rd_end && is_addr(rd_addr_q, `DPC_ADDR_PARITY_FRAME);
  wire clr_pp  = rd_end && is_addr(rd_addr_q, `DPC_ADDR_PBIT_ERR);

  dpc_sat_counter #(.WIDTH(CNT_W)) u_fb (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .inc_in        (fb_inc),
    .inhibit_in    (inhibit),
    .read_busy_in  (busy_fb),
    .read_clear_in (clr_fb),
    .count_out     (cnt_fb)
  );
  dpc_sat_counter #(.WIDTH(CNT_W)) u_cp (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .inc_in        (cp_inc),
    .inhibit_in    (inhibit),
    .read_busy_in  (busy_cp),
    .read_clear_in (clr_cp),
    .count_out     (cnt_cp)
  );
  dpc_sat_counter #(.WIDTH(CNT_W)) u_pp (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .inc_in        (pp_inc),
    .inhibit_in    (inhibit),
    .read_busy_in  (busy_pp),
    .read_clear_in (clr_pp),
    .count_out     (cnt_pp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command register and read data
  reg  [7:0] cmd_q;
  wire       cmd_wr = wr_in && (addr_in == `DPC_ADDR_LOOP_CMD);
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_q     <= `DPC_CMD_RESET;
      rdata_out <= 8'h00;
    end else if (clk_en_in) begin
      if (cmd_wr)
        cmd_q <= wdata_in;
      // Data is taken at the strobe edge; the clear waits for the strobe to drop
      if (rd_in) begin
        case (addr_in)
          `DPC_ADDR_FAR_END_ERR:  rdata_out <= cnt_fb;
          `DPC_ADDR_PARITY_FRAME: rdata_out <= cnt_cp;
          `DPC_ADDR_PBIT_ERR:     rdata_out <= cnt_pp;
          `DPC_ADDR_LOOP_CMD:     rdata_out <= cmd_q;
          default:                rdata_out <= 8'h00;
        endcase
      end
    end
  end

  wire       w_go     = wdata_in[`DPC_BIT_GO];
  // method bit only honoured in C-bit mode
  wire       w_feac   = wdata_in[`DPC_BIT_METHOD] & cbit_mode_in;
  wire [4:0] w_tgt    = wdata_in[4:0];
  // legal targets are all, DS1 1..28, or DS3 with the FEAC method
  wire       w_ds1    = (w_tgt >= `DPC_CODE_DS1_FIRST);
  wire       w_legal  = (w_tgt == `DPC_CODE_ALL) | w_ds1 |
                        ((w_tgt == `DPC_CODE_DS3) & w_feac);

  ////////////////////////////////////////////////////////////////////////////
  // Inversion request
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      inversion_active_out  <= 1'b0;
      inversion_target_out  <= 5'h00;
      inversion_pattern_out <= 4'h0;
    end else if (clk_en_in) begin
      // pattern taken from the select bits
      inversion_pattern_out <= inversion_pattern_select_in;
      if (cmd_wr && !w_feac) begin
        // go starts, clear stops; up/down ignored
        // a new target replaces the old one
        // Target follows every inversion write, even a refused one
        inversion_active_out <= w_go & w_legal & (w_tgt != `DPC_CODE_DS3);
        inversion_target_out <= w_tgt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FEAC double message sender
  // Writes during a message are stored, not sent: one message at a time
  reg [1:0]  st_q;
  reg [15:0] word_q;
  reg [3:0]  bit_q;
  reg [3:0]  rep_q;
  reg [5:0]  cmd_code_q;
  reg [5:0]  chan_q;
  // FEAC only in C-bit mode and with clock select set
  wire       feac_start = cmd_wr && w_go && w_feac && w_legal && feac_clock_select_in;
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_q          <= ST_IDLE;
      word_q        <= 16'hffff;
      bit_q         <= 4'h0;
      rep_q         <= 4'h0;
      cmd_code_q    <= 6'h00;
      chan_q        <= 6'h00;
      feac_bit_out  <= 1'b1;
      feac_busy_out <= 1'b0;
    end else if (clk_en_in) begin
      case (st_q)
        ST_IDLE: begin
          feac_bit_out  <= 1'b1;
          feac_busy_out <= 1'b0;
          // start only when the request is legal
          if (feac_start) begin
            cmd_code_q    <= wdata_in[`DPC_BIT_UP_DOWN] ? `DPC_FEAC_CONNECT
                                                        : `DPC_FEAC_DISCONNECT;
            word_q        <= feac_word(wdata_in[`DPC_BIT_UP_DOWN] ? `DPC_FEAC_CONNECT
                                                                  : `DPC_FEAC_DISCONNECT);
            chan_q        <= chan_code(w_tgt);
            bit_q         <= 4'h0;
            rep_q         <= 4'h0;
            feac_busy_out <= 1'b1;
            st_q          <= ST_CMD;
          end
        end
        ST_CMD, ST_CHAN: begin
          if (bit_ev) begin
            feac_bit_out <= word_q[0];
            word_q       <= {1'b1, word_q[15:1]};
            bit_q        <= bit_q + 4'h1;
            if (bit_q == 4'hf) begin
              if (rep_q == `DPC_FEAC_REPEATS - 4'h1) begin
                rep_q  <= 4'h0;
                word_q <= feac_word(chan_q);
                st_q   <= (st_q == ST_CMD) ? ST_CHAN : ST_DONE;
              end else begin
                rep_q  <= rep_q + 4'h1;
                word_q <= feac_word((st_q == ST_CMD) ? cmd_code_q : chan_q);
              end
            end
          end
        end
        // One idle slot closes the message before busy drops
        ST_DONE: begin
          if (bit_ev) begin
            feac_bit_out <= 1'b1;
            st_q         <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- dpc_perf_loop_assertions.sv
// Port checker for the DS3 counter and loopback block
`timescale 1ns/10ps
module dpc_perf_loop_assertions (
  // Watched ports
  input wire       clk_in,
  input wire       reset_n_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       cbit_mode_in,
  input wire [3:0] inversion_pattern_select_in,
  input wire       feac_clock_select_in,
  input wire       feac_bit_out,
  input wire       inversion_active_out,
  input wire [4:0] inversion_target_out,
  input wire [3:0] inversion_pattern_out,
  input wire       feac_busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire       cmd = wr_in && addr_in == 8'h07 && wdata_in[7];
  wire       inv = wr_in && addr_in == 8'h07 && !wdata_in[5];
  wire [4:0] code = wdata_in[4:0];
  ////////////////////////////////
  property p_legal;
    inversion_active_out |-> inversion_target_out == 5'h00 || inversion_target_out > 5'h03;
  endproperty
  a_legal: assert property (p_legal) else $error("bad target");
  property p_pattern;
    $past(reset_n_in) |-> inversion_pattern_out == $past(inversion_pattern_select_in);
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern copy");
  property p_idle;
    !feac_busy_out && !$past(feac_busy_out) |-> feac_bit_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle bit");
  property p_m13;
    cmd && wdata_in[5] && !cbit_mode_in && !feac_busy_out |=> !feac_busy_out [*4];
  endproperty
  a_m13: assert property (p_m13) else $error("feac in m13");
  // Busy rises the cycle after the write; the window allows up to 20 cycles
  property p_start;
    cmd && wdata_in[5] && cbit_mode_in && feac_clock_select_in && !feac_busy_out
      && (code == 5'h00 || code == 5'h02 || code > 5'h03) |-> ##[1:20] feac_busy_out;
  endproperty
  a_start: assert property (p_start) else $error("feac start");
  property p_hold;
    $rose(feac_busy_out) |-> feac_busy_out [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("feac short");
  property p_run;
    inv && wdata_in[7] && code > 5'h03
      |=> inversion_active_out && inversion_target_out == $past(code);
  endproperty
  a_run: assert property (p_run) else $error("inv start");
  property p_stop;
    inv && !wdata_in[7] |=> !inversion_active_out;
  endproperty
  a_stop: assert property (p_stop) else $error("inv stop");
  c_feac: cover property ($rose(feac_busy_out));
  c_inv: cover property ($rose(inversion_active_out));
  c_stop: cover property ($fell(inversion_active_out));
endmodule
bind dpc_perf_loop dpc_perf_loop_assertions dpc_perf_loop_assertions_i (
  .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .cbit_mode_in,
  .inversion_pattern_select_in, .feac_clock_select_in, .feac_bit_out,
  .inversion_active_out, .inversion_target_out, .inversion_pattern_out, .feac_busy_out
);

//--- dpc_far_end_model.sv
// Far-end terminal: FEAC bit clock and tally of zero bits
`timescale 1ns/10ps
module dpc_far_end_model (
  // Clock and tally
  input  wire        clk_in,
  input  wire        clr_in,
  input  wire        feac_bit_in,
  output logic       tick_out,
  output logic [8:0] zeros_out
);
  logic [3:0] ph_q = 4'h0;
  // Line clock runs free; sample late in the slot, clear of sync delay
  always @(posedge clk_in) begin
    ph_q <= ph_q + 4'h1;
    tick_out <= ph_q < 4'h8;
    if (clr_in) begin
      zeros_out <= 9'h000;
    end else if (ph_q == 4'hf && !feac_bit_in) begin
      zeros_out <= zeros_out + 9'h001;
    end
  end
endmodule

//--- dpc_perf_loop_tb_top.sv
// Self-checking bench for the DS3 counter and loopback block
`timescale 1ns/10ps
`include "dpc_defines.vh"
module dpc_perf_loop_tb_top;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        cbit_q = 1'b0;
  logic [3:0]  pat_q = 4'h0;
  logic        fsel_q = 1'b0;
  logic        tick_q = 1'b0;
  logic [2:0]  febe_q = 3'h7;
  logic [2:0]  err_q = 3'h0;
  logic        los_q = 1'b0;
  logic        oof_q = 1'b0;
  logic        clr_q = 1'b1;
  logic [7:0]  got, g2;
  logic [31:0] rng = 32'h40;
  wire  [7:0]  rdata_out;
  wire         fbit, act, busy, ftick;
  wire  [4:0]  tgt;
  wire  [3:0]  pat;
  wire  [8:0]  zeros;
  int          failures = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n, a;
  dpc_perf_loop dpc_perf_loop_i (
    .clk_in, .reset_n_in, .clk_en_in(1'b1), .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .cbit_mode_in(cbit_q), .inversion_pattern_select_in(pat_q),
    .feac_clock_select_in(fsel_q), .frame_tick_in(tick_q), .febe_bits_in(febe_q),
    .fm_bit_err_in(err_q[0]), .cparity_err_in(err_q[1]), .pbit_err_in(err_q[2]),
    .ds3_los_in(los_q), .ds3_oof_in(oof_q), .feac_bit_tick_in(ftick),
    .feac_bit_out(fbit), .inversion_active_out(act), .inversion_target_out(tgt),
    .inversion_pattern_out(pat), .feac_busy_out(busy)
  );
  dpc_far_end_model dpc_far_end_model_i (
    .clk_in, .clr_in(clr_q), .feac_bit_in(fbit), .tick_out(ftick), .zeros_out(zeros)
  );
  ////////////////////////////////
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  function automatic int rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return int'(rng[15:0]);
  endfunction
  task automatic check(string what, int exp, logic [7:0] seen);
    comparisons++;
    if (seen !== exp[7:0]) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Reference model: one integer per counter, saturating, cleared by a read
  int mdl [3] = '{0, 0, 0};
  function automatic void bump(int k, int cnt);
    if (!los_q && !oof_q)
      mdl[k] = (mdl[k] + cnt > 255) ? 255 : mdl[k] + cnt;
  endfunction
  task automatic tick(int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= ad;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, output logic [7:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= ad;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    v = rdata_out;
  endtask
  task automatic crd(logic [7:0] ad, int exp);
    rd(ad, got);
    check("register", exp, got);
    if (ad >= 8'h04 && ad <= 8'h06) begin
      check("model", mdl[ad - 8'h04], got);
      mdl[ad - 8'h04] = 0;
    end
  endtask
  // Each cycle an error line stays high is one count
  task automatic ev(int k, int cnt);
    repeat (cnt) begin
      @(posedge clk_in);
      err_q[k] <= 1'b1;
    end
    @(posedge clk_in);
    err_q[k] <= 1'b0;
    tick(6);
    if (k == 2 || (k == 0 && !cbit_q) || (k == 1 && cbit_q))
      bump(k, cnt);
  endtask
  task automatic frames(int cnt);
    repeat (cnt) begin
      @(posedge clk_in);
      tick_q <= 1'b1;
      tick(3);
      tick_q <= 1'b0;
      tick(3);
    end
    tick(6);
    if (cbit_q)
      bump(0, (febe_q == 3'h7) ? 0 : cnt);
    else
      bump(1, cnt);
  endtask
  task automatic feac(logic [7:0] cmd, int exp);
    int zq [$];
    int mz;
    mz = 0;
    repeat (`DPC_FEAC_REPEATS) zq.push_back(cmd[6] ? `DPC_FEAC_CONNECT : `DPC_FEAC_DISCONNECT);
    repeat (`DPC_FEAC_REPEATS) zq.push_back(cmd[4:0]);
    // Each word is 0xxxxxx0 then ones: two framing zeros plus the code's zeros
    for (int i = 0; i < zq.size(); i++) mz += 8 - $countones(zq[i]);
    @(posedge clk_in);
    clr_q <= 1'b1;
    @(posedge clk_in);
    clr_q <= 1'b0;
    wr(8'h07, cmd);
    for (n = 0; n < 40 && busy !== 1'b1; n++) tick(1);
    for (n = 0; n < 9000 && busy !== 1'b0; n++) tick(1);
    tick(20);
    check("zero bits", exp, zeros[7:0]);
    check("model zeros", mz, zeros[7:0]);
  endtask
  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    tick(4);
    reset_n_in <= 1'b1;
    clr_q <= 1'b0;
    for (a = 4; a < 9; a++) crd(a[7:0], 0);
    $display("test reset done");
    n = rnd() % 20 + 1;
    ev(2, n);
    crd(8'h06, n);
    crd(8'h06, 0);
    ev(0, 3);
    crd(8'h04, 3);
    frames(5);
    crd(8'h05, 5);
    ev(0, 300);
    crd(8'h04, 255);
    los_q <= 1'b1;
    ev(2, 4);
    los_q <= 1'b0;
    oof_q <= 1'b1;
    ev(0, 4);
    oof_q <= 1'b0;
    crd(8'h06, 0);
    crd(8'h04, 0);
    fork
      begin
        tick(2);
        rd(8'h06, got);
      end
      ev(2, 1);
    join
    rd(8'h06, g2);
    check("held increment", 1, got + g2);
    mdl[2] = 0;
    $display("test counters done");
    cbit_q <= 1'b1;
    tick(5);
    febe_q <= 3'h5;
    frames(4);
    febe_q <= 3'h7;
    frames(2);
    crd(8'h04, 4);
    ev(1, 3);
    crd(8'h05, 3);
    $display("test cbit done");
    n = rnd() % 28 + 4;
    pat_q <= 4'(rnd());
    wr(8'h07, {3'b110, n[4:0]});
    tick(1);
    check("active", 1, act);
    check("target", n, tgt);
    check("pattern", pat_q, pat);
    a = (n - 3) % 28 + 4;
    wr(8'h07, {3'b100, a[4:0]});
    tick(1);
    check("target", a, tgt);
    wr(8'h07, 8'h04);
    tick(1);
    check("active", 0, act);
    wr(8'h07, 8'h82);
    tick(1);
    check("active", 0, act);
    crd(8'h07, 8'h82);
    $display("test inversion done");
    fsel_q <= 1'b1;
    feac(8'he4, 120);
    feac(8'ha0, 130);
    cbit_q <= 1'b0;
    tick(5);
    wr(8'h07, 8'he4);
    tick(20);
    check("busy", 0, busy);
    $display("test feac done");
    close_out();
  end
endmodule
